/* include/aww_defines.svh */
`ifndef AWW_DEFINES_SVH
`define AWW_DEFINES_SVH

// System clock rate and slow oscillator rate.
`define AWW_CLK_MHZ 250
`define AWW_SLOW_HZ 32768

// Register byte offsets.
`define AWW_ADDR_CTRL 8'h00
`define AWW_ADDR_LOAD 8'h04
`define AWW_ADDR_WINDOW 8'h08
`define AWW_ADDR_SERVICE 8'h0C
`define AWW_ADDR_COUNT 8'h10
`define AWW_ADDR_RST_STAT 8'h14
`define AWW_ADDR_IRQ_STAT 8'h18
`define AWW_ADDR_IRQ_MASK 8'h1C

// Control field positions.
`define AWW_CTRL_WDT_EN 0
`define AWW_CTRL_WAKE_EN 1
`define AWW_CTRL_SEL_LO 2
`define AWW_CTRL_SEL_HI 4

// Interrupt status bit positions.
`define AWW_IRQ_WAKE 0
`define AWW_IRQ_WINDOW 1

// Reset values.
`define AWW_CTRL_RST 5'h00
`define AWW_LOAD_RST 16'h8000
`define AWW_WINDOW_RST 16'hFFFF

// Bus responses.
`define AWW_RESP_OKAY 2'h0
`define AWW_RESP_SLVERR 2'h2

// Reset pulse length, as a time and as system clock cycles.
`define AWW_RST_PULSE_NS 1000
`define AWW_RST_PULSE_CYC ((`AWW_RST_PULSE_NS * `AWW_CLK_MHZ) / 1000)

// Shortest wake-up period, as a time and as slow ticks.
`define AWW_WAKE_BASE_MS 125
`define AWW_WAKE_BASE_TICKS ((`AWW_WAKE_BASE_MS * `AWW_SLOW_HZ) / 1000)
`define AWW_WAKE_SEL_MAX 3'h6

`endif

/* include/aww_pkg.sv */
package aww_pkg;

  // Watchdog sequencer states.
  typedef enum logic [1:0] {
    wd_off,
    wd_run,
    wd_rst
  } aww_wd_state_t;

endpackage : aww_pkg

/* verilog/aww_windowed_watchdog.sv */
// Implementation choices: the AXI4-Lite slave port and the address map.
`include "aww_defines.svh"

// Overview of operation
// - A missed service lets the counter run out and resets the device.
// - The wake-up timer pulses every 125 ms to 8 s, chosen by a selector.
// - The watchdog counts only ticks of the 32 kHz oscillator.
// - A watchdog reset sets a cause flag in the reset status register.
// - A watchdog reset clears some bits and keeps others, bit by bit.
// - The watchdog reset drives both the processor and front-end resets.
// - A service that arrives before the window opens causes a reset.
module aww_windowed_watchdog (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Slow oscillator pin.
  input wire logic osc32k_i,
  // Reset, wake-up and interrupt outputs.
  output logic cpu_reset_o,
  output logic afe_reset_o,
  output logic wake_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  // Merges write data into a register under the byte strobes.
  function automatic logic [31:0] aww_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = data[8*i +: 8];
      end
    end
    aww_merge = r;
  endfunction : aww_merge

  // Tells whether a byte address holds a register.
  function automatic logic aww_mapped(input logic [7:0] a);
    aww_mapped = (a == `AWW_ADDR_CTRL) || (a == `AWW_ADDR_LOAD) ||
                 (a == `AWW_ADDR_WINDOW) || (a == `AWW_ADDR_SERVICE) ||
                 (a == `AWW_ADDR_COUNT) || (a == `AWW_ADDR_RST_STAT) ||
                 (a == `AWW_ADDR_IRQ_STAT) || (a == `AWW_ADDR_IRQ_MASK);
  endfunction : aww_mapped

  // Turns the period selector into slow ticks, doubling per step.
  function automatic logic [18:0] aww_wake_ticks(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > `AWW_WAKE_SEL_MAX) ? `AWW_WAKE_SEL_MAX : sel;
    aww_wake_ticks = 19'(`AWW_WAKE_BASE_TICKS) << s;
  endfunction : aww_wake_ticks

  ////////////////////////////////////////////////////////////////////////////
  // Slow oscillator synchroniser and tick detector.

  logic osc_s1;
  logic osc_s2;
  logic osc_s3;
  logic tick;

  // Two stages catch the pin, a third marks the rising edge.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc32k_i;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  // Only this tick advances the watchdog and wake-up counters, never the system clock.
  assign tick = osc_s2 & ~osc_s3;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave.

  logic aw_held, next_aw_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic wr_go;

  // Every control reaches the block only through this slave.
  assign wr_go = aw_held & w_held & ~bvalid;
  assign s_axi_awready_o = ~aw_held;
  assign s_axi_wready_o = ~w_held;
  assign s_axi_arready_o = ~rvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rdata_o = rdata;
  assign s_axi_rresp_o = rresp;

  // Register file contents, declared here for the read mux.
  logic [4:0] ctrl, next_ctrl;
  logic [15:0] load, next_load;
  logic [15:0] window, next_window;
  logic rst_cause, next_rst_cause;
  logic [1:0] irq_stat, next_irq_stat;
  logic [1:0] irq_mask, next_irq_mask;
  logic [15:0] watchdog_down_counter, next_counter;

  // Address and data are caught in either order, then written together.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_awvalid_i && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata_i;
      next_w_strb = s_axi_wstrb_i;
    end
    if (bvalid && s_axi_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = aww_mapped(aw_addr) ? `AWW_RESP_OKAY : `AWW_RESP_SLVERR;
    end
    if (rvalid && s_axi_rready_i) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = aww_mapped(s_axi_araddr_i) ? `AWW_RESP_OKAY :
                   `AWW_RESP_SLVERR;
      case (s_axi_araddr_i)
        `AWW_ADDR_CTRL: next_rdata = {27'h000_0000, ctrl};
        `AWW_ADDR_LOAD: next_rdata = {16'h0000, load};
        `AWW_ADDR_WINDOW: next_rdata = {16'h0000, window};
        `AWW_ADDR_COUNT: next_rdata = {16'h0000, watchdog_down_counter};
        `AWW_ADDR_RST_STAT: next_rdata = {31'h0000_0000, rst_cause};
        `AWW_ADDR_IRQ_STAT: next_rdata = {30'h0000_0000, irq_stat};
        `AWW_ADDR_IRQ_MASK: next_rdata = {30'h0000_0000, irq_mask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Registers the bus channel state.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `AWW_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `AWW_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Windowed watchdog sequencer.

  aww_pkg::aww_wd_state_t state, next_state;
  logic [8:0] pulse_cnt, next_pulse_cnt;
  logic rst_q, next_rst_q;
  logic svc;
  logic wd_fire;
  logic win_evt;
  logic [15:0] cnt_dec;

  assign svc = wr_go && (aw_addr == `AWW_ADDR_SERVICE);
  assign cnt_dec = watchdog_down_counter - 16'h0001;

  // Counts ticks down, checks the window on service, issues the reset.
  always_comb begin
    next_state = state;
    next_counter = watchdog_down_counter;
    next_pulse_cnt = pulse_cnt;
    wd_fire = 1'b0;
    win_evt = 1'b0;
    case (state)
      aww_pkg::wd_off: begin
        if (ctrl[`AWW_CTRL_WDT_EN]) begin
          next_state = aww_pkg::wd_run;
          next_counter = load;
        end
      end
      aww_pkg::wd_run: begin
        if (!ctrl[`AWW_CTRL_WDT_EN]) begin
          next_state = aww_pkg::wd_off;
        end else if (svc) begin
          if (watchdog_down_counter > window) begin
            wd_fire = 1'b1;
          end else begin
            next_counter = load;
          end
        end else if (tick) begin
          if (watchdog_down_counter <= 16'h0001) begin
            wd_fire = 1'b1;
          end else begin
            next_counter = cnt_dec;
            win_evt = (cnt_dec == window);
          end
        end
        if (wd_fire) begin
          next_state = aww_pkg::wd_rst;
          next_pulse_cnt = 9'(`AWW_RST_PULSE_CYC - 1);
          next_counter = load;
        end
      end
      aww_pkg::wd_rst: begin
        if (pulse_cnt == 9'h000) begin
          next_state = aww_pkg::wd_off;
        end else begin
          next_pulse_cnt = pulse_cnt - 9'h001;
        end
      end
      default: next_state = aww_pkg::wd_off;
    endcase
    next_rst_q = (next_state == aww_pkg::wd_rst);
  end

  // Registers the sequencer.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= aww_pkg::wd_off;
      watchdog_down_counter <= `AWW_LOAD_RST;
      pulse_cnt <= 9'h000;
      rst_q <= 1'b0;
    end else begin
      state <= next_state;
      watchdog_down_counter <= next_counter;
      pulse_cnt <= next_pulse_cnt;
      rst_q <= next_rst_q;
    end
  end

  // One flop drives both reset domains so they act as one.
  assign cpu_reset_o = rst_q;
  assign afe_reset_o = rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up timer.

  logic [18:0] wake_cnt, next_wake_cnt;
  logic wake_q, next_wake_q;
  logic [18:0] wake_period;

  assign wake_period = aww_wake_ticks(ctrl[`AWW_CTRL_SEL_HI:`AWW_CTRL_SEL_LO]);

  // Counts slow ticks and pulses once per selected period.
  always_comb begin
    next_wake_cnt = wake_cnt;
    next_wake_q = 1'b0;
    if (!ctrl[`AWW_CTRL_WAKE_EN]) begin
      next_wake_cnt = wake_period - 19'h0_0001;
    end else if (tick) begin
      if (wake_cnt == 19'h0_0000) begin
        next_wake_q = 1'b1;
        next_wake_cnt = wake_period - 19'h0_0001;
      end else begin
        next_wake_cnt = wake_cnt - 19'h0_0001;
      end
    end
  end

  // Registers the wake-up timer.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_cnt <= 19'h0_0000;
      wake_q <= 1'b0;
    end else begin
      wake_cnt <= next_wake_cnt;
      wake_q <= next_wake_q;
    end
  end

  assign wake_o = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and interrupt.

  logic irq_q, next_irq_q;
  logic [31:0] wmerged;
  logic [31:0] m_ctrl;
  logic [31:0] m_load;
  logic [31:0] m_window;
  logic [31:0] m_mask;

  assign wmerged = aww_merge(32'h0000_0000, w_data, w_strb);

  // Each writable register merged with the strobed write data.
  assign m_ctrl = aww_merge({27'h000_0000, ctrl}, w_data, w_strb);
  assign m_load = aww_merge({16'h0000, load}, w_data, w_strb);
  assign m_window = aww_merge({16'h0000, window}, w_data, w_strb);
  assign m_mask = aww_merge({30'h0000_0000, irq_mask}, w_data, w_strb);

  // Applies writes, sticky events and the watchdog reset effects.
  always_comb begin
    next_ctrl = ctrl;
    next_load = load;
    next_window = window;
    next_irq_mask = irq_mask;
    next_rst_cause = rst_cause;
    next_irq_stat = irq_stat;
    if (wr_go) begin
      case (aw_addr)
        `AWW_ADDR_CTRL: next_ctrl = m_ctrl[4:0];
        `AWW_ADDR_LOAD: next_load = m_load[15:0];
        `AWW_ADDR_WINDOW: next_window = m_window[15:0];
        `AWW_ADDR_IRQ_MASK: next_irq_mask = m_mask[1:0];
        `AWW_ADDR_RST_STAT:
          next_rst_cause = rst_cause & ~wmerged[0];
        `AWW_ADDR_IRQ_STAT:
          next_irq_stat = irq_stat & ~wmerged[1:0];
        default: next_ctrl = ctrl;
      endcase
    end
    // Events set after the clear, so a set in the same cycle wins.
    next_irq_stat[`AWW_IRQ_WAKE] = next_irq_stat[`AWW_IRQ_WAKE] | next_wake_q;
    next_irq_stat[`AWW_IRQ_WINDOW] = next_irq_stat[`AWW_IRQ_WINDOW] | win_evt;
    if (wd_fire) begin
      next_ctrl[`AWW_CTRL_WAKE_EN] = 1'b0;
      next_irq_mask = 2'h0;
      next_irq_stat = 2'h0;
      next_rst_cause = 1'b1;
    end
    next_irq_q = |(next_irq_stat & next_irq_mask);
  end

  // Registers the register file; limits, watchdog enable and cause survive.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `AWW_CTRL_RST;
      load <= `AWW_LOAD_RST;
      window <= `AWW_WINDOW_RST;
      irq_mask <= 2'h0;
      rst_cause <= 1'b0;
      irq_stat <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      load <= next_load;
      window <= next_window;
      irq_mask <= next_irq_mask;
      rst_cause <= next_rst_cause;
      irq_stat <= next_irq_stat;
      irq_q <= next_irq_q;
    end
  end

  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  logic run_en;
  assign run_en = (state == aww_pkg::wd_run) && ctrl[`AWW_CTRL_WDT_EN];

  sequence s_rst_hold;
    (cpu_reset_o && afe_reset_o)[*8];
  endsequence

  property p_zero_fire;
    (run_en && !svc && tick && watchdog_down_counter == 16'h0001) |=>
      (state == aww_pkg::wd_rst) && cpu_reset_o;
  endproperty
  a_zero_fire: assert property (p_zero_fire)
    else $error("Expired counter gave no reset.");

  property p_wake_period;
    (ctrl[`AWW_CTRL_WAKE_EN] && !wr_go && tick && wake_cnt == 19'h0_0000)
      |=> wake_o && (wake_cnt == aww_wake_ticks(
        ctrl[`AWW_CTRL_SEL_HI:`AWW_CTRL_SEL_LO]) - 19'h0_0001);
  endproperty
  a_wake_period: assert property (p_wake_period)
    else $error("Wake-up pulse or reload wrong.");

  property p_slow_only;
    (state == aww_pkg::wd_run && !tick && !svc) |=>
      $stable(watchdog_down_counter);
  endproperty
  a_slow_only: assert property (p_slow_only)
    else $error("Counter moved without a slow tick.");

  property p_cause;
    wd_fire |=> rst_cause ##1 rst_cause;
  endproperty
  a_cause: assert property (p_cause)
    else $error("Reset cause flag not set.");

  property p_retain;
    (wd_fire && !wr_go) |=> !ctrl[`AWW_CTRL_WAKE_EN] &&
      (irq_mask == 2'h0) && $stable(load) && $stable(window);
  endproperty
  a_retain: assert property (p_retain)
    else $error("Reset effect on registers wrong.");

  property p_both_resets;
    wd_fire |=> s_rst_hold;
  endproperty
  a_both_resets: assert property (p_both_resets)
    else $error("Resets not held together.");

  property p_early;
    (run_en && svc && watchdog_down_counter > window) |=>
      cpu_reset_o && afe_reset_o;
  endproperty
  a_early: assert property (p_early)
    else $error("Early service gave no reset.");

  property p_reload;
    (run_en && svc && watchdog_down_counter <= window) |=>
      (watchdog_down_counter == $past(load)) && !cpu_reset_o;
  endproperty
  a_reload: assert property (p_reload)
    else $error("Valid service did not reload.");

endmodule : aww_windowed_watchdog

/* tb/tb.sv */
`include "aww_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // Bench signals; the driven inputs and the counters are given a value at time zero.
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic osc = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic cpu_reset_o, afe_reset_o, wake_o, irq_o;
  logic [31:0] seed = 32'h974f_4371;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rst_hi = 0;
  int afe_hi = 0;
  int wake_n = 0;
  int rst_base = 0;
  int afe_base = 0;
  logic [1:0] rsp;
  logic [31:0] ld;

  aww_windowed_watchdog aww_windowed_watchdog_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .osc32k_i(osc),
    .cpu_reset_o(cpu_reset_o), .afe_reset_o(afe_reset_o),
    .wake_o(wake_o), .irq_o(irq_o)
  );

  // The system clock toggles every half period of 2 ns.
  always #2 clk_sys_i = ~clk_sys_i;

  // Output activity is tallied mid-cycle, where it has settled.
  // A hang is cut short here as well.
  always @(negedge clk_sys_i) begin
    if (cpu_reset_o === 1'b1) rst_hi++;
    if (afe_reset_o === 1'b1) afe_hi++;
    if (wake_o === 1'b1) wake_n++;
    cyc++;
    if (cyc > 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Xorshift source with a fixed seed, so every run is the same.
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Compares one result and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Write cycle; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r, input logic [3:0] s = 4'hf);
    bit da, dw, ta, tw, tb_;
    da = 0;
    dw = 0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk_sys_i);
      ta = !da && awready === 1'b1;
      tw = !dw && wready === 1'b1;
      @(posedge clk_sys_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    do begin
      @(negedge clk_sys_i);
      tb_ = bvalid === 1'b1;
      r = bresp;
      @(posedge clk_sys_i);
    end while (!tb_);
    bready <= 1'b0;
  endtask : wr

  // Read cycle; data and response are sampled mid-cycle, just before the accepting edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit ta, tr;
    ta = 0;
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk_sys_i);
      ta = arready === 1'b1;
      @(posedge clk_sys_i);
    end while (!ta);
    arvalid <= 1'b0;
    do begin
      @(negedge clk_sys_i);
      tr = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk_sys_i);
    end while (!tr);
    rready <= 1'b0;
  endtask : rd

  // Reads one register and checks both its value and an OKAY answer.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, `AWW_RESP_OKAY});
  endtask : rd_chk

  // n slow oscillator periods; the last tick has landed when it returns.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      osc <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      osc <= 1'b0;
      repeat (3 + rnd() % 3) @(posedge clk_sys_i);
    end
  endtask : tick

  // Checks the pulse length on both reset outputs since the last check.
  task automatic fire_chk(input int exp);
    repeat (300) @(negedge clk_sys_i);
    chk(rst_hi - rst_base, exp);
    chk(afe_hi - afe_base, exp);
    rst_base = rst_hi;
    afe_base = afe_hi;
  endtask : fire_chk

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // Reset values, then unmapped and unaligned places.
    rd_chk(`AWW_ADDR_CTRL, 32'h0000_0000);
    rd_chk(`AWW_ADDR_LOAD, 32'h0000_8000);
    rd_chk(`AWW_ADDR_WINDOW, 32'h0000_ffff);
    wr(`AWW_ADDR_COUNT, rnd(), rsp);
    chk({30'h0, rsp}, {30'h0, `AWW_RESP_OKAY});
    rd_chk(`AWW_ADDR_COUNT, 32'h0000_8000);
    rd_chk(`AWW_ADDR_IRQ_STAT, 32'h0000_0000);
    rd_chk(`AWW_ADDR_IRQ_MASK, 32'h0000_0000);
    // Byte strobes: only the second byte of the limit is replaced.
    wr(`AWW_ADDR_WINDOW, 32'h1234_5678, rsp, 4'h2);
    rd_chk(`AWW_ADDR_WINDOW, 32'h0000_56ff);
    rd_chk(`AWW_ADDR_RST_STAT, 32'h0000_0000);
    rd(8'h20, ld, rsp);
    chk({30'h0, rsp}, {30'h0, `AWW_RESP_SLVERR});
    chk(ld, 32'h0000_0000);
    wr(8'h02, rnd(), rsp);
    chk({30'h0, rsp}, {30'h0, `AWW_RESP_SLVERR});
    // Selector field readback over every period choice.
    for (int s = 0; s < 8; s++) begin
      wr(`AWW_ADDR_CTRL, s << 2, rsp);
      rd_chk(`AWW_ADDR_CTRL, s << 2);
    end
    // Unserviced counter runs out and fires both resets.
    ld = 6 + rnd() % 8;
    wr(`AWW_ADDR_LOAD, ld, rsp);
    wr(`AWW_ADDR_IRQ_MASK, 32'h0000_0003, rsp);
    wr(`AWW_ADDR_CTRL, 32'h0000_0003, rsp);
    tick(ld - 1);
    rd_chk(`AWW_ADDR_COUNT, 32'h0000_0001);
    tick(1);
    fire_chk(`AWW_RST_PULSE_CYC);
    rd_chk(`AWW_ADDR_RST_STAT, 32'h0000_0001);
    rd_chk(`AWW_ADDR_CTRL, 32'h0000_0001);
    rd_chk(`AWW_ADDR_IRQ_MASK, 32'h0000_0000);
    rd_chk(`AWW_ADDR_LOAD, ld);
    rd_chk(`AWW_ADDR_COUNT, ld);
    wr(`AWW_ADDR_RST_STAT, 32'h0000_0001, rsp);
    rd_chk(`AWW_ADDR_RST_STAT, 32'h0000_0000);
    // Early service while the count is above the window fires.
    wr(`AWW_ADDR_LOAD, 32'h0000_0008, rsp);
    wr(`AWW_ADDR_WINDOW, 32'h0000_0004, rsp);
    wr(`AWW_ADDR_SERVICE, rnd(), rsp);
    fire_chk(`AWW_RST_PULSE_CYC);
    rd_chk(`AWW_ADDR_RST_STAT, 32'h0000_0001);
    wr(`AWW_ADDR_RST_STAT, 32'h0000_0001, rsp);
    // Window opening is flagged, masked, unmasked and cleared.
    tick(4);
    rd_chk(`AWW_ADDR_COUNT, 32'h0000_0004);
    rd_chk(`AWW_ADDR_IRQ_STAT, 32'h0000_0002);
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    wr(`AWW_ADDR_IRQ_MASK, 32'h0000_0002, rsp);
    repeat (2) @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0001);
    // No oscillator edges means no counting.
    repeat (200) @(posedge clk_sys_i);
    rd_chk(`AWW_ADDR_COUNT, 32'h0000_0004);
    // Service exactly at the window value reloads without a reset.
    wr(`AWW_ADDR_SERVICE, rnd(), rsp);
    chk({30'h0, rsp}, {30'h0, `AWW_RESP_OKAY});
    rd_chk(`AWW_ADDR_COUNT, 32'h0000_0008);
    fire_chk(0);
    rd_chk(`AWW_ADDR_RST_STAT, 32'h0000_0000);
    wr(`AWW_ADDR_IRQ_STAT, 32'h0000_0002, rsp);
    repeat (2) @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0000);
    rd_chk(`AWW_ADDR_IRQ_STAT, 32'h0000_0000);
    // Wake-up timer at the shortest period, watchdog off.
    wr(`AWW_ADDR_CTRL, 32'h0000_0002, rsp);
    wr(`AWW_ADDR_IRQ_MASK, 32'h0000_0001, rsp);
    tick(`AWW_WAKE_BASE_TICKS - 1);
    chk(wake_n, 0);
    tick(1);
    chk(wake_n, 1);
    rd_chk(`AWW_ADDR_IRQ_STAT, 32'h0000_0001);
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0001);
    fire_chk(0);
    wrap_up();
  end

endmodule : tb
